/* File: hdl/rsg_top.sv */
// Operation
// R01: Squelch count uses receive-mask step and range
// R02: Squelch switches on about 20 us after transmit
// R03: Count above 5 ends squelch on own timer; code also requires sqt_q < mrt_q, else the receive-mask timer ends it
// R04: Own-timer end freezes gain as AGC start
// R05: Otherwise squelch lasts until receive-mask timer expiry
// R06: Guard count steps are 2048 carrier periods
// R07: Guard value applies during field-on commands
// R08: Guard time adds to fixed 75 us start
// R09: Host programs 33 initial, 0 active guard
// R10: Main mask bit one suppresses that source
// R11: Timer/field mask bit one suppresses that source
// R12: Error/wake mask bit one suppresses that source
// R13: All mask bits reset to zero
// R14: Step select: 0 fine, 1 coarse step
// R15: Status register clears after host read
// R16: Masked event recorded but raises no interrupt
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rsg_top
    import rsg_pkg::*;
(
    input wire logic hclk, // Bus clock
    input wire logic hresetn, // Async reset
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write strobe
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Always OKAY
    input wire rsg_pkg::rsg_evt_t evt, // Interrupt event pulses
    input wire logic tx_end, // Reader transmit finished
    input wire logic field_on_cmd, // Field-on command start
    output logic irq, // Interrupt request
    output logic squelch_en, // Receiver squelch on
    output logic agc_hold, // Frozen gain seeds AGC
    output logic mrt_run, // Receive-mask timer running
    output logic guard_active // Field guard running
);
    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic rd_pend_q, rd_pend_d, wr_pend_q, wr_pend_d, hit_q, hit_d;
    logic [7:0] idx_q, idx_d;
    logic [31:0] hrdata_d;
    logic hready_d;
    logic take, do_rd, do_wr;
    logic [7:0] rdval;
    logic [7:0] sqt_q, guard_q, mmain_q, mtnfc_q, merr_q, mrt_q, ctrl_q;
    logic [7:0] smain_q, stnfc_q, serr_q;
    logic guard_evt;

    assign take = hsel && htrans[1] && hready;
    assign do_rd = rd_pend_q && hit_q;
    assign do_wr = wr_pend_q && hit_q;

    always_comb
    begin
        rd_pend_d = 1'b0;
        wr_pend_d = 1'b0;
        hit_d = hit_q;
        idx_d = idx_q;
        hready_d = 1'b1;
        hrdata_d = hrdata;
        if (rd_pend_q || wr_pend_q)
        begin
            hrdata_d = {24'h000000, rd_pend_q ? rdval : 8'h00};
        end
        else if (take)
        begin
            // One wait state lets a write land before any later read
            rd_pend_d = !hwrite;
            wr_pend_d = hwrite;
            idx_d = haddr[ADDR_MSB:ADDR_LSB];
            hit_d = (haddr[31:ADDR_MSB+1] == '0);
            hready_d = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_pend_q <= 1'b0;
            wr_pend_q <= 1'b0;
            hit_q <= 1'b0;
            idx_q <= 8'h00;
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
            hresp <= 1'b0;
        end
        else
        begin
            rd_pend_q <= rd_pend_d;
            wr_pend_q <= wr_pend_d;
            hit_q <= hit_d;
            idx_q <= idx_d;
            hreadyout <= hready_d;
            hrdata <= hrdata_d;
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers, status and interrupt
    // ------------------------------------------------------------
    logic [7:0] sqt_d, guard_d, mmain_d, mtnfc_d, merr_d, mrt_d, ctrl_d;
    logic [7:0] smain_d, stnfc_d, serr_d, wd;
    logic irq_d;
    logic [7:0] tnfc_ev;

    assign wd = hwdata[7:0];
    assign tnfc_ev = evt.tnfc | (8'(guard_evt) << TNFC_GUARD_BIT);

    always_comb
    begin
        case (idx_q)
            IDX_SQT: rdval = sqt_q;
            IDX_GUARD: rdval = guard_q;
            IDX_MMAIN: rdval = mmain_q;
            IDX_MTNFC: rdval = mtnfc_q;
            IDX_MERR: rdval = merr_q;
            IDX_SMAIN: rdval = smain_q;
            IDX_STNFC: rdval = stnfc_q;
            IDX_SERR: rdval = serr_q;
            IDX_STATE: rdval = {4'h0, guard_active, mrt_run, agc_hold, squelch_en};
            IDX_MRT: rdval = mrt_q;
            IDX_CTRL: rdval = ctrl_q;
            default: rdval = 8'h00;
        endcase
        if (!hit_q)
        begin
            rdval = 8'h00;
        end
    end

    always_comb
    begin
        sqt_d = (do_wr && idx_q == IDX_SQT) ? wd : sqt_q;
        guard_d = (do_wr && idx_q == IDX_GUARD) ? wd : guard_q;
        mmain_d = (do_wr && idx_q == IDX_MMAIN) ? (wd & MAIN_USED) : mmain_q;
        mtnfc_d = (do_wr && idx_q == IDX_MTNFC) ? wd : mtnfc_q;
        merr_d = (do_wr && idx_q == IDX_MERR) ? wd : merr_q;
        mrt_d = (do_wr && idx_q == IDX_MRT) ? wd : mrt_q;
        ctrl_d = (do_wr && idx_q == IDX_CTRL) ? (wd & 8'h01) : ctrl_q;
        // Read clears the whole register, write-one clears bits; a new event wins
        smain_d = smain_q;
        stnfc_d = stnfc_q;
        serr_d = serr_q;
        if (do_rd && idx_q == IDX_SMAIN) smain_d = 8'h00; // [R15]
        if (do_rd && idx_q == IDX_STNFC) stnfc_d = 8'h00; // [R15]
        if (do_rd && idx_q == IDX_SERR) serr_d = 8'h00; // [R15]
        if (do_wr && idx_q == IDX_SMAIN) smain_d = smain_q & ~wd;
        if (do_wr && idx_q == IDX_STNFC) stnfc_d = stnfc_q & ~wd;
        if (do_wr && idx_q == IDX_SERR) serr_d = serr_q & ~wd;
        smain_d = smain_d | (evt.main & MAIN_USED); // [R16]
        stnfc_d = stnfc_d | tnfc_ev; // [R16]
        serr_d = serr_d | evt.errw; // [R16]
        irq_d = |(smain_q & ~mmain_q & MAIN_USED) // [R10]
            || |(stnfc_q & ~mtnfc_q) // [R11]
            || |(serr_q & ~merr_q); // [R12]
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sqt_q <= RST_SQT;
            guard_q <= RST_GUARD;
            mmain_q <= RST_MASK; // [R13]
            mtnfc_q <= RST_MASK; // [R13]
            merr_q <= RST_MASK; // [R13]
            mrt_q <= RST_MRT;
            ctrl_q <= 8'h00;
            smain_q <= 8'h00;
            stnfc_q <= 8'h00;
            serr_q <= 8'h00;
            irq <= 1'b0;
        end
        else
        begin
            sqt_q <= sqt_d;
            guard_q <= guard_d;
            mmain_q <= mmain_d;
            mtnfc_q <= mtnfc_d;
            merr_q <= merr_d;
            mrt_q <= mrt_d;
            ctrl_q <= ctrl_d;
            smain_q <= smain_d;
            stnfc_q <= stnfc_d;
            serr_q <= serr_d;
            irq <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // Squelch and receive-mask timer
    // ------------------------------------------------------------
    rsg_sq_t sq_q, sq_d;
    logic [15:0] pre_q, pre_d, dly_q, dly_d, step_cyc;
    logic [7:0] stp_q, stp_d;
    logic sq_own, own_end, mrt_end, sq_en_d, hold_d, run_d;

    assign step_cyc = ctrl_q[CTRL_STEP_BIT] ? STEP_COARSE_CYC : STEP_FINE_CYC; // [R14]
    assign sq_own = (sqt_q > SQT_MIN) && (sqt_q < mrt_q); // [R03] [R05]
    assign own_end = sq_own && (stp_q >= sqt_q); // [R01] [R03]
    assign mrt_end = stp_q >= mrt_q; // [R05]

    always_comb
    begin
        sq_d = sq_q;
        pre_d = pre_q;
        stp_d = stp_q;
        dly_d = dly_q;
        sq_en_d = squelch_en;
        hold_d = agc_hold;
        run_d = mrt_run;
        if (tx_end)
        begin
            sq_d = SQ_WAIT;
            pre_d = 16'h0000;
            stp_d = 8'h00;
            dly_d = 16'h0000;
            sq_en_d = 1'b0;
            hold_d = 1'b0;
            run_d = 1'b1;
        end
        else
        begin
            if (mrt_run)
            begin
                // Both timers share one step prescaler and count
                // Compare with >= so a step change mid-count cannot run the prescaler away
                if (pre_q >= step_cyc - 16'h0001) // [R01] [R14]
                begin
                    pre_d = 16'h0000;
                    stp_d = stp_q + 8'h01;
                end
                else
                begin
                    pre_d = pre_q + 16'h0001;
                end
                if (mrt_end)
                begin
                    run_d = 1'b0;
                end
            end
            case (sq_q)
                SQ_WAIT:
                begin
                    dly_d = dly_q + 16'h0001;
                    if (own_end || mrt_end)
                    begin
                        sq_d = SQ_IDLE;
                    end
                    else if (dly_q == SQ_DELAY_CYC - 16'h0001) // [R02]
                    begin
                        sq_d = SQ_ON;
                        sq_en_d = 1'b1;
                    end
                end
                SQ_ON:
                begin
                    if (own_end) // [R03]
                    begin
                        sq_d = SQ_IDLE;
                        sq_en_d = 1'b0;
                        hold_d = 1'b1; // [R04]
                    end
                    else if (mrt_end) // [R05]
                    begin
                        sq_d = SQ_IDLE;
                        sq_en_d = 1'b0;
                    end
                end
                default:
                begin
                    sq_d = SQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sq_q <= SQ_IDLE;
            pre_q <= 16'h0000;
            stp_q <= 8'h00;
            dly_q <= 16'h0000;
            squelch_en <= 1'b0;
            agc_hold <= 1'b0;
            mrt_run <= 1'b0;
        end
        else
        begin
            sq_q <= sq_d;
            pre_q <= pre_d;
            stp_q <= stp_d;
            dly_q <= dly_d;
            squelch_en <= sq_en_d;
            agc_hold <= hold_d;
            mrt_run <= run_d;
        end
    end

    // ------------------------------------------------------------
    // Field-on guard timer
    // ------------------------------------------------------------
    rsg_gd_t gd_q, gd_d;
    logic [15:0] gcnt_q, gcnt_d;
    logic [7:0] gstp_q, gstp_d, gsnap_q, gsnap_d;
    logic gact_d, gevt_d, gevt_q;

    assign guard_evt = gevt_q;

    always_comb
    begin
        gd_d = gd_q;
        gcnt_d = gcnt_q + 16'h0001;
        gstp_d = gstp_q;
        gsnap_d = gsnap_q;
        gact_d = guard_active;
        gevt_d = 1'b0;
        case (gd_q)
            GD_IDLE:
            begin
                gcnt_d = 16'h0000;
                if (field_on_cmd) // [R07]
                begin
                    gd_d = GD_INIT;
                    gsnap_d = guard_q;
                    gstp_d = 8'h00;
                    gact_d = 1'b1;
                end
            end
            GD_INIT:
            begin
                if (gcnt_q == GUARD_INIT_CYC - 16'h0001) // [R08]
                begin
                    gd_d = GD_STEP;
                    gcnt_d = 16'h0000;
                end
            end
            GD_STEP:
            begin
                if (gstp_q == gsnap_q) // [R06] [R08]
                begin
                    gd_d = GD_IDLE;
                    gact_d = 1'b0;
                    gevt_d = 1'b1;
                end
                else if (gcnt_q == GUARD_STEP_CYC - 16'h0001) // [R06]
                begin
                    gcnt_d = 16'h0000;
                    gstp_d = gstp_q + 8'h01;
                end
            end
            default:
            begin
                gd_d = GD_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            gd_q <= GD_IDLE;
            gcnt_q <= 16'h0000;
            gstp_q <= 8'h00;
            gsnap_q <= 8'h00;
            guard_active <= 1'b0;
            gevt_q <= 1'b0;
        end
        else
        begin
            gd_q <= gd_d;
            gcnt_q <= gcnt_d;
            gstp_q <= gstp_d;
            gsnap_q <= gsnap_d;
            guard_active <= gact_d;
            gevt_q <= gevt_d;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_sq_delay_on: assert property ((sq_q == SQ_WAIT && !tx_end && !own_end && !mrt_end // [R02]
        && dly_q == SQ_DELAY_CYC - 16'h0001) |=> squelch_en) else $error("squelch late");
    a_sq_off_tx: assert property (tx_end |=> !squelch_en && !agc_hold && mrt_run) // [R02]
        else $error("tx end not restarting");
    a_sq_own_end: assert property ((squelch_en && own_end && !tx_end) |=> !squelch_en && agc_hold) // [R03]
        else $error("own end missed");
    a_agc_frozen: assert property ((agc_hold && !tx_end) |=> agc_hold && !squelch_en) // [R04]
        else $error("gain hold lost");
    // Squelch and the mask timer drop on the same edge, so mrt_end may be seen with squelch still on
    a_sq_mrt_hold: assert property ((squelch_en && !sq_own) |-> mrt_run) // [R05]
        else $error("squelch outlived mask timer");
    a_sq_mrt_end: assert property ((squelch_en && !sq_own && mrt_end && !tx_end) // [R05]
        |=> !squelch_en && !mrt_run) else $error("mask timer end missed");
    a_step_select: assert property ((mrt_run && !tx_end && pre_q == step_cyc - 16'h0001) // [R01] [R14]
        |=> pre_q == 16'h0000 && stp_q == $past(stp_q) + 8'h01) else $error("step size");
    a_guard_init: assert property ((gd_q == GD_INIT && gcnt_q == GUARD_INIT_CYC - 16'h0001) // [R08]
        |=> gd_q == GD_STEP && gcnt_q == 16'h0000) else $error("guard start time");
    a_guard_end: assert property ((gd_q == GD_STEP && gstp_q == gsnap_q) // [R06] [R07]
        |=> !guard_active ##1 stnfc_q[TNFC_GUARD_BIT]) else $error("guard end");
    a_mask_reset: assert property ($rose(hresetn) |-> mmain_q == RST_MASK // [R13]
        && mtnfc_q == RST_MASK && merr_q == RST_MASK) else $error("mask reset");
    a_irq_masked: assert property ((((smain_q & ~mmain_q & MAIN_USED) | (stnfc_q & ~mtnfc_q) // [R10] [R11] [R12] [R16]
        | (serr_q & ~merr_q)) == 8'h00) |=> !irq) else $error("masked irq");
    a_rd_clear: assert property ((do_rd && idx_q == IDX_SERR) |=> serr_q == $past(evt.errw)) // [R15]
        else $error("read clear");

    c_own_end: cover property (squelch_en && own_end);
    c_mrt_end: cover property (squelch_en && !sq_own && mrt_end);
    c_guard_done: cover property (gevt_q);
    c_irq: cover property ($rose(irq));
endmodule : rsg_top
`default_nettype wire

/* File: hdl/rsg_pkg.sv */
`default_nettype none
package rsg_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_SQT = 8'h0F;
    localparam logic [7:0] IDX_GUARD = 8'h15;
    localparam logic [7:0] IDX_MMAIN = 8'h16;
    localparam logic [7:0] IDX_MTNFC = 8'h17;
    localparam logic [7:0] IDX_MERR = 8'h18;
    localparam logic [7:0] IDX_SMAIN = 8'h1A;
    localparam logic [7:0] IDX_STNFC = 8'h1B;
    localparam logic [7:0] IDX_SERR = 8'h1C;
    localparam logic [7:0] IDX_STATE = 8'h1D;
    localparam logic [7:0] IDX_MRT = 8'h1E;
    localparam logic [7:0] IDX_CTRL = 8'h1F;
    localparam int ADDR_LSB = 2;
    localparam int ADDR_MSB = 9;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] RST_SQT = 8'h00;
    localparam logic [7:0] RST_GUARD = 8'h33;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_MRT = 8'h00;
    localparam logic [7:0] MAIN_USED = 8'hFE;
    localparam logic [7:0] SQT_MIN = 8'h05;
    localparam int CTRL_STEP_BIT = 0;
    localparam int TNFC_GUARD_BIT = 1;

    // ------------------------------------------------------------
    // Timing, in nanoseconds, and derived clock counts
    // ------------------------------------------------------------
    localparam int CLK_NS = 100;
    localparam int SQ_DELAY_NS = 20000;
    localparam int STEP_FINE_NS = 4720;
    localparam int STEP_COARSE_NS = 37760;
    localparam int GUARD_INIT_NS = 75000;
    localparam int GUARD_STEP_NS = 151000;
    localparam logic [15:0] SQ_DELAY_CYC = 16'(SQ_DELAY_NS / CLK_NS);
    localparam logic [15:0] STEP_FINE_CYC = 16'(STEP_FINE_NS / CLK_NS);
    localparam logic [15:0] STEP_COARSE_CYC = 16'(STEP_COARSE_NS / CLK_NS);
    localparam logic [15:0] GUARD_INIT_CYC = 16'(GUARD_INIT_NS / CLK_NS);
    localparam logic [15:0] GUARD_STEP_CYC = 16'(GUARD_STEP_NS / CLK_NS);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] main;
        logic [7:0] tnfc;
        logic [7:0] errw;
    } rsg_evt_t;
    typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_ON} rsg_sq_t;
    typedef enum logic [1:0] {GD_IDLE, GD_INIT, GD_STEP} rsg_gd_t;
endpackage : rsg_pkg
`default_nettype wire

/* File: verif/test_rsg_top.sv */
`timescale 1ns/1ps
`default_nettype none
module test_rsg_top;
    import rsg_pkg::*;
    logic hclk, hresetn, hsel, hwrite, tx_end, field_on_cmd;
    logic [31:0] haddr, hwdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    rsg_evt_t evt;
    wire logic [31:0] hrdata;
    wire logic hready, hresp, irq, squelch_en, agc_hold, mrt_run, guard_active;
    int miscompares = 0;
    int check_count = 0;
    logic [31:0] rd;

    rsg_top rsg_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .evt(evt), .tx_end(tx_end), .field_on_cmd(field_on_cmd),
        .irq(irq), .squelch_en(squelch_en), .agc_hold(agc_hold), .mrt_run(mrt_run),
        .guard_active(guard_active));

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task print_verdict;
        if (miscompares == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    task check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task wait_cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : wait_cyc

    // Waits at falling edges so the level seen is what the next rising edge samples
    task wait_ready;
        int n;
        n = 0;
        @(negedge hclk);
        while (hready !== 1'b1 && n < 100)
        begin
            @(negedge hclk);
            n++;
        end
        if (n >= 100)
            miscompares++;
    endtask : wait_ready

    task bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready();
        @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        @(posedge hclk);
    endtask : bus

    task bus_chk(input logic [7:0] idx, input logic [31:0] exp);
        bus(idx, 1'b0, 32'h0);
        check(rd, exp);
    endtask : bus_chk

    task pulse(input logic [23:0] e, input logic t, input logic f);
        @(posedge hclk);
        evt <= rsg_evt_t'(e);
        tx_end <= t;
        field_on_cmd <= f;
        @(posedge hclk);
        evt <= rsg_evt_t'(24'h0);
        tx_end <= 1'b0;
        field_on_cmd <= 1'b0;
    endtask : pulse

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task reset_values;
        bus_chk(IDX_SQT, 32'h0);
        bus_chk(IDX_GUARD, 32'h33);
        bus_chk(IDX_MMAIN, 32'h0);
        bus_chk(IDX_MTNFC, 32'h0);
        bus_chk(IDX_MERR, 32'h0);
        bus(8'h10, 1'b1, 32'hFF);
        bus_chk(8'h10, 32'h0);
        check({31'h0, hresp}, 32'h0);
        check({31'h0, irq}, 32'h0);
    endtask : reset_values

    task mask_rw;
        bus(IDX_MMAIN, 1'b1, 32'hFF);
        bus(IDX_MTNFC, 1'b1, 32'hFF);
        bus(IDX_MERR, 1'b1, 32'hFF);
        bus_chk(IDX_MMAIN, 32'hFE);
        bus_chk(IDX_MTNFC, 32'hFF);
        bus_chk(IDX_MERR, 32'hFF);
        bus(IDX_MMAIN, 1'b1, 32'h0);
        bus(IDX_MTNFC, 1'b1, 32'h0);
        bus(IDX_MERR, 1'b1, 32'h0);
    endtask : mask_rw

    // Each source masked alone, then unmasked; main bit 0 has no source at all
    task irq_bits;
        logic [7:0] idx, sidx, bv, ex;
        for (int k = 0; k < 3; k++)
        begin
            for (int b = 0; b < 8; b++)
            begin
                idx = IDX_MMAIN + 8'(k);
                sidx = IDX_SMAIN + 8'(k);
                bv = 8'h01 << b;
                ex = (k == 0 && b == 0) ? 8'h00 : bv;
                bus(idx, 1'b1, {24'h0, bv});
                pulse(24'(bv) << (8 * (2 - k)), 1'b0, 1'b0);
                wait_cyc(3);
                check({31'h0, irq}, 32'h0);
                bus_chk(sidx, {24'h0, ex});
                bus_chk(sidx, 32'h0);
                bus(idx, 1'b1, 32'h0);
                pulse(24'(bv) << (8 * (2 - k)), 1'b0, 1'b0);
                wait_cyc(3);
                check({31'h0, irq}, {31'h0, |ex});
                bus(sidx, 1'b1, {24'h0, bv});
                wait_cyc(3);
                check({31'h0, irq}, 32'h0);
            end
        end
    endtask : irq_bits

    task squelch_run(input logic [7:0] sq, input logic [7:0] mr, input logic stp, input logic own);
        int step, t_end;
        step = stp ? 377 : 47;
        t_end = (own ? int'(sq) : int'(mr)) * step;
        bus(IDX_CTRL, 1'b1, {31'h0, stp});
        bus(IDX_SQT, 1'b1, {24'h0, sq});
        bus(IDX_MRT, 1'b1, {24'h0, mr});
        pulse(24'h0, 1'b1, 1'b0);
        wait_cyc(188);
        @(negedge hclk);
        check({31'h0, squelch_en}, 32'h0);
        check({31'h0, mrt_run}, 32'h1);
        wait_cyc(20);
        @(negedge hclk);
        check({31'h0, squelch_en}, 32'h1);
        wait_cyc(t_end - 220);
        @(negedge hclk);
        check({30'h0, squelch_en, agc_hold}, 32'h2);
        wait_cyc(20);
        @(negedge hclk);
        check({31'h0, squelch_en}, 32'h0);
        check({31'h0, agc_hold}, {31'h0, own});
        check({31'h0, mrt_run}, {31'h0, own});
        wait_cyc(int'(mr) * step - t_end + 20);
        check({31'h0, mrt_run}, 32'h0);
    endtask : squelch_run

    // Mask timer ends before the switch-on delay: squelch must never come on
    task squelch_short;
        logic seen;
        seen = 1'b0;
        bus(IDX_CTRL, 1'b1, 32'h0);
        bus(IDX_SQT, 1'b1, 32'h0);
        bus(IDX_MRT, 1'b1, 32'h3);
        pulse(24'h0, 1'b1, 1'b0);
        repeat (250)
        begin
            @(negedge hclk);
            seen = seen | squelch_en;
        end
        check({31'h0, seen}, 32'h0);
        check({31'h0, mrt_run}, 32'h0);
        check({31'h0, agc_hold}, 32'h0);
    endtask : squelch_short

    // A second command while the guard runs must not restart it
    task guard_run(input logic [7:0] gv);
        int t_end;
        t_end = 750 + int'(gv) * 1510;
        bus(IDX_GUARD, 1'b1, {24'h0, gv});
        pulse(24'h0, 1'b0, 1'b1);
        wait_cyc(5);
        check({31'h0, guard_active}, 32'h1);
        bus_chk(IDX_STATE, 32'h08);
        pulse(24'h0, 1'b0, 1'b1);
        wait_cyc(t_end - 20);
        @(negedge hclk);
        check({31'h0, guard_active}, 32'h1);
        wait_cyc(20);
        @(negedge hclk);
        check({31'h0, guard_active}, 32'h0);
        wait_cyc(4);
        check({31'h0, irq}, 32'h1);
        bus_chk(IDX_STNFC, 32'h02);
        wait_cyc(3);
        check({31'h0, irq}, 32'h0);
    endtask : guard_run

    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // Whole run is about 61k cycles, mostly the 33-step guard; stop at 80k
    initial
    begin
        #8000000;
        miscompares++;
        print_verdict();
    end

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        evt = rsg_evt_t'(24'h0);
        tx_end = 1'b0;
        field_on_cmd = 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        reset_values();
        mask_rw();
        irq_bits();
        squelch_run(8'h06, 8'h14, 1'b0, 1'b1);
        squelch_run(8'h05, 8'h0A, 1'b0, 1'b0);
        squelch_run(8'h0A, 8'h0A, 1'b0, 1'b0);
        squelch_run(8'h06, 8'h07, 1'b1, 1'b1);
        squelch_short();
        guard_run(8'h00);
        guard_run(8'h02);
        guard_run(8'h21);
        print_verdict();
    end
endmodule : test_rsg_top
`default_nettype wire
